/* File: tb/psta_mem_model.sv */
// Behavioural program array: two 16-bit word spaces side by side, answering after a set delay.
// Assumes the requester holds mem_req and its qualifiers until the one-cycle mem_ack.
module psta_mem_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic        mem_hi,
	input  wire logic [22:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic [1:0]  mem_wstrb,
	input  wire logic [3:0]  dly,
	output logic      [15:0] mem_rdata,
	output logic             mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Storage, keyed by space select above the word address
	// ------------------------------------------------------------
	logic [15:0] mem [logic [23:0]];
	logic [3:0]  wait_cnt;
	logic [23:0] key;
	logic [15:0] cur;

	assign key = {mem_hi, mem_addr};

	// Unwritten words read as the inverted address
	function automatic logic [15:0] peek(input logic [23:0] k);
		return mem.exists(k) ? mem[k] : ~k[15:0];
	endfunction

	// Answer one request; the data lines keep toggling while no answer stands
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_ack   <= 1'b0;
			wait_cnt  <= 4'h0;
			mem_rdata <= 16'h5A5A;
		end else if (mem_req && !mem_ack && wait_cnt >= dly) begin
			cur = peek(key);
			mem_ack   <= 1'b1;
			wait_cnt  <= 4'h0;
			mem_rdata <= cur;
			if (mem_we) begin
				mem[key] = {mem_wstrb[1] ? mem_wdata[15:8] : cur[15:8],
					mem_wstrb[0] ? mem_wdata[7:0] : cur[7:0]};
			end
		end else begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack)
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

/* File: tb/psta_top_tb.sv */
// Self-checking bench of the table-access block, AHB-Lite master and array model.
// Assumes hready is the slave's own hreadyout and whole-word single transfers.
module psta_top_tb;
	import psta_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals and bench state
	// ------------------------------------------------------------
	logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, seed;
	logic [1:0]  htrans, mem_wstrb, cap_strb;
	logic [2:0]  hsize;
	logic        mem_req, mem_we, mem_hi, mem_ack, cfg_space, psv_suspend;
	logic [22:0] mem_addr, cap_addr;
	logic [15:0] mem_wdata, mem_rdata, cap_wdata;
	logic [3:0]  dly;
	logic        seen, cap_hi, cap_we, cap_cfg;
	logic [15:0] shadow [logic [23:0]];
	int          error_cnt, total_checks, cyc;

	assign hready = hreadyout;

	psta_top u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_we(mem_we),
		.mem_hi(mem_hi), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wstrb(mem_wstrb),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .cfg_space(cfg_space),
		.psv_suspend(psv_suspend));

	psta_mem_model u_mem (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
		.mem_hi(mem_hi), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wstrb(mem_wstrb),
		.dly(dly), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Data word a table read must return
	function automatic logic [15:0] exp_rd(input logic hi, input logic bm, input logic bs,
		input logic [15:0] w);
		if (!hi)
			return bm ? {8'h00, bs ? w[15:8] : w[7:0]} : w;
		return (bm && bs) ? 16'h0000 : {8'h00, w[7:0]};
	endfunction

	// Lane strobes a table write must raise
	function automatic logic [1:0] exp_strb(input logic hi, input logic bm, input logic bs);
		if (hi)
			return (bm && bs) ? 2'b00 : 2'b01;
		return bm ? (bs ? 2'b10 : 2'b01) : 2'b11;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic complete_run();
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One AHB-Lite single transfer; read data taken at the closing edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h00_0000, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask

	task automatic poll(output logic [31:0] rd);
		int n;
		n = 0;
		do begin
			bus(1'b0, PSTA_OFF_STATUS, 32'h0000_0000, rd);
			n++;
		end while (rd[0] !== 1'b0 && n < 100);
	endtask

	// Full table operation with all checks at the array port and registers
	task automatic run_op(input logic [1:0] op, input logic bm, input logic inc,
		input logic [7:0] pg, input logic [15:0] ea, input logic [15:0] wd);
		logic [31:0] rd;
		logic [23:0] key;
		logic [15:0] cur, ewd;
		logic [1:0]  stb;
		logic        req;
		key = {op[0], pg, ea[15:1]};
		cur = shadow.exists(key) ? shadow[key] : ~key[15:0];
		ewd = bm ? {wd[7:0], wd[7:0]} : wd;
		stb = exp_strb(op[0], bm, ea[0]);
		req = !(op == PSTA_OP_WR_HI && bm && ea[0]);
		dly <= 4'(rnd());
		bus(1'b1, PSTA_OFF_PAGE, {24'h00_0000, pg}, rd);
		bus(1'b1, PSTA_OFF_EA, {16'h0000, ea}, rd);
		bus(1'b1, PSTA_OFF_WDATA, {16'h0000, wd}, rd);
		seen = 1'b0;
		bus(1'b1, PSTA_OFF_CMD, {28'h000_0000, inc, bm, op}, rd);
		@(posedge clk);
		chk(32'(psv_suspend), 32'h0000_0001, "window not held");
		poll(rd);
		chk({30'h0, rd[1:0]}, {30'h0, pg[7], 1'b0}, "status");
		chk(32'(seen), 32'(req), "request");
		if (req) begin
			chk({cap_hi, cap_we, cap_cfg, cap_addr}, {op[0], op[1], pg[7], pg, ea[15:1]},
				"array addr");
			bus(1'b0, PSTA_OFF_EA, 32'h0000_0000, rd);
			chk(rd, {16'h0000, inc ? ea + (bm ? PSTA_BYTE_STEP : PSTA_WORD_STEP) : ea},
				"ea step");
		end
		if (req && op[1]) begin
			chk({14'h0, cap_strb, cap_wdata}, {14'h0, stb, ewd}, "write lanes");
			shadow[key] = {stb[1] ? ewd[15:8] : cur[15:8], stb[0] ? ewd[7:0] : cur[7:0]};
		end
		if (!op[1]) begin
			bus(1'b0, PSTA_OFF_RDATA, 32'h0000_0000, rd);
			chk(rd, {16'h0000, exp_rd(op[0], bm, ea[0], cur)}, "read data");
		end
	endtask

	// ------------------------------------------------------------
	// Clock, capture of accepted array requests, timeout
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (mem_req === 1'b1 && mem_ack === 1'b1) begin
			seen      <= 1'b1;
			cap_hi    <= mem_hi;
			cap_we    <= mem_we;
			cap_cfg   <= cfg_space;
			cap_addr  <= mem_addr;
			cap_wdata <= mem_wdata;
			cap_strb  <= mem_wstrb;
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic [31:0] r;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		dly = 4'h0;
		seed = 32'd18937;
		error_cnt = 0;
		total_checks = 0;
		cyc = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Reset values, then an unmapped place
		for (int a = 0; a <= 8'h20; a += 4) begin
			bus(1'b0, 8'(a), 32'h0000_0000, rd);
			chk(rd, 32'h0000_0000, "reset value");
		end
		bus(1'b1, 8'h20, 32'hFFFF_FFFF, rd);
		bus(1'b0, 8'h20, 32'h0000_0000, rd);
		chk({rd[31:1], hresp}, 32'h0000_0000, "unmapped");
		// Every op, size and byte select, user and configuration pages
		for (int i = 0; i < 16; i++)
			run_op(2'(i), i[2], 1'b1, {i[0], 7'h02}, {15'h0010, i[3]}, 16'hA55A ^ 16'(i));
		run_op(PSTA_OP_RD_LO, 1'b0, 1'b1, 8'h7F, 16'hFFFE, 16'h0000);
		// Command while busy is dropped and flagged, then cleared
		bus(1'b1, PSTA_OFF_EA, 32'h0000_0040, rd);
		dly <= 4'hF;
		bus(1'b1, PSTA_OFF_CMD, 32'h0000_0008, rd);
		bus(1'b1, PSTA_OFF_CMD, 32'h0000_000B, rd);
		bus(1'b0, PSTA_OFF_STATUS, 32'h0000_0000, rd);
		chk({29'h0, rd[2], 1'b0, rd[0]}, 32'h0000_0005, "busy refusal");
		poll(rd);
		bus(1'b1, PSTA_OFF_STATUS, 32'h0000_0004, rd);
		bus(1'b0, PSTA_OFF_STATUS, 32'h0000_0000, rd);
		chk({29'h0, rd[2], 1'b0, rd[0]}, 32'h0000_0000, "flag clear");
		bus(1'b0, PSTA_OFF_EA, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0042, "ea after op");
		// Random traffic over a small window so reads meet earlier writes
		repeat (40) begin
			r = rnd();
			run_op(r[1:0], r[2], r[3], {r[4], 6'h00, r[5]}, {12'h000, r[11:8]}, r[31:16]);
		end
		complete_run();
	end
endmodule

/* File: verilog/psta_ahb_cap.sv */
// AHB-Lite phase tracker: turns address phases into write and read strobes.
// Assumes single word transfers; reads take one wait state so data comes from a flop.
module psta_ahb_cap
	import psta_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       hsel,
	input  wire logic [7:0] haddr_lo,
	input  wire logic [1:0] htrans,
	input  wire logic       hwrite,
	input  wire logic       hready,
	psta_bus_if.cap         bus
);

	typedef struct packed {
		logic       ph_wr;
		logic       ph_rd;
		logic [7:0] addr;
	} psta_cap_t;

	psta_cap_t cap_reg;
	psta_cap_t cap_next;

	// Address phase accepted on NONSEQ or SEQ with hready high
	always_comb begin
		cap_next = cap_reg;
		cap_next.ph_wr = hsel & htrans[1] & hready & hwrite;
		cap_next.ph_rd = hsel & htrans[1] & hready & ~hwrite;
		if (hsel & htrans[1] & hready) begin
			cap_next.addr = haddr_lo;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cap_reg <= '0;
		end else begin
			cap_reg <= cap_next;
		end
	end

	// Strobes to the register file
	assign bus.wr_en   = cap_reg.ph_wr;
	assign bus.rd_en   = cap_reg.ph_rd;
	assign bus.rd_wait = cap_reg.ph_rd; // First read data cycle is a wait state
	assign bus.addr    = cap_reg.addr;

endmodule

/* File: verilog/psta_if.sv */
// Carriers between the table-access top and its two helper modules.
// Assumes all parties run on the same clock.

// ------------------------------------------------------------
// Bus phase tracker to register file
// ------------------------------------------------------------
interface psta_bus_if;
	logic       wr_en;
	logic       rd_en;
	logic       rd_wait;
	logic [7:0] addr;
	modport cap  (output wr_en, output rd_en, output rd_wait, output addr);
	modport regs (input wr_en, input rd_en, input rd_wait, input addr);
endinterface

// ------------------------------------------------------------
// Sequencer to byte-lane formatter
// ------------------------------------------------------------
interface psta_lane_if;
	import psta_pkg::*;
	psta_op_t    op;
	logic        byte_mode;
	logic        bsel;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] rd_fmt;
	logic [15:0] wr_data;
	logic [1:0]  wr_strb;
	modport core (output op, output byte_mode, output bsel, output wdata, output rdata,
		input rd_fmt, input wr_data, input wr_strb);
	modport lane (input op, input byte_mode, input bsel, input wdata, input rdata,
		output rd_fmt, output wr_data, output wr_strb);
endinterface

/* File: verilog/psta_lane.sv */
// Byte-lane formatter for table reads and writes of program words.
// Assumes high-space words hold the upper program byte in bits 7:0; bits 15:8 are phantom.
module psta_lane
	import psta_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	psta_lane_if.lane lane
);

	// Read formatting per operation and mode
	function automatic logic [15:0] psta_read_fmt(psta_op_t op, logic bm, logic bs,
		logic [15:0] d);
		logic [15:0] f;
		f = 16'h0000;
		if (op == PSTA_OP_RD_LO) begin
			f = bm ? {8'h00, (bs ? d[15:8] : d[7:0])} : d;
		end else if (op == PSTA_OP_RD_HI) begin
			f = {8'h00, ((bm & bs) ? 8'h00 : d[7:0])};
		end
		return f;
	endfunction

	// Write strobes; a phantom byte write selects no lane
	function automatic logic [1:0] psta_write_strb(psta_op_t op, logic bm, logic bs);
		logic [1:0] s;
		s = 2'h0;
		if (op == PSTA_OP_WR_LO) begin
			s = bm ? (bs ? 2'h2 : 2'h1) : 2'h3;
		end else if (op == PSTA_OP_WR_HI) begin
			s = (bm & bs) ? 2'h0 : 2'h1;
		end
		return s;
	endfunction

	// Formatter outputs
	assign lane.rd_fmt  = psta_read_fmt(lane.op, lane.byte_mode, lane.bsel, lane.rdata);
	assign lane.wr_strb = psta_write_strb(lane.op, lane.byte_mode, lane.bsel);
	assign lane.wr_data = lane.byte_mode ? {lane.wdata[7:0], lane.wdata[7:0]} : lane.wdata;

	// Read format checks
	a_lo_word_read: assert property (@(posedge clk) disable iff (rst)
		(lane.op == PSTA_OP_RD_LO && !lane.byte_mode) |-> lane.rd_fmt == lane.rdata)
		else $error("low word read altered the data");
	a_lo_byte_read: assert property (@(posedge clk) disable iff (rst)
		(lane.op == PSTA_OP_RD_LO && lane.byte_mode) |-> lane.rd_fmt ==
		{8'h00, (lane.bsel ? lane.rdata[15:8] : lane.rdata[7:0])})
		else $error("low byte read picked the wrong byte");
	a_hi_word_read: assert property (@(posedge clk) disable iff (rst)
		(lane.op == PSTA_OP_RD_HI && !lane.byte_mode) |->
		(lane.rd_fmt[15:8] == 8'h00 && lane.rd_fmt[7:0] == lane.rdata[7:0]))
		else $error("high word read wrong");
	a_hi_byte_read: assert property (@(posedge clk) disable iff (rst)
		(lane.op == PSTA_OP_RD_HI && lane.byte_mode && !lane.bsel) |->
		lane.rd_fmt == {8'h00, lane.rdata[7:0]})
		else $error("high byte read wrong");
	a_phantom_zero: assert property (@(posedge clk) disable iff (rst)
		(lane.op == PSTA_OP_RD_HI && lane.byte_mode && lane.bsel) |-> lane.rd_fmt == 16'h0000)
		else $error("phantom byte read not zero");

endmodule

/* File: verilog/psta_pkg.sv */
// Constants, register map and enumerations of the program-space table-access block.
// Assumes a 32-bit AHB-Lite register bus and a 16-bit wide program memory array port.
package psta_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] PSTA_OFF_PAGE   = 8'h00;
	localparam logic [7:0] PSTA_OFF_EA     = 8'h04;
	localparam logic [7:0] PSTA_OFF_WDATA  = 8'h08;
	localparam logic [7:0] PSTA_OFF_CMD    = 8'h0C;
	localparam logic [7:0] PSTA_OFF_RDATA  = 8'h10;
	localparam logic [7:0] PSTA_OFF_STATUS = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned PSTA_CMD_OP_LSB   = 0;
	localparam int unsigned PSTA_CMD_BYTE_BIT = 2;
	localparam int unsigned PSTA_CMD_INC_BIT  = 3;
	localparam int unsigned PSTA_ST_BUSY_BIT  = 0;
	localparam int unsigned PSTA_ST_CFG_BIT   = 1;
	localparam int unsigned PSTA_ST_IGN_BIT   = 2;
	localparam int unsigned PSTA_PAGE_CFG_BIT = 7;

	// ------------------------------------------------------------
	// Reset values and address steps
	// ------------------------------------------------------------
	localparam logic [7:0]  PSTA_PAGE_RST  = 8'h00;
	localparam logic [15:0] PSTA_EA_RST    = 16'h0000;
	localparam logic [15:0] PSTA_DATA_RST  = 16'h0000;
	localparam logic [31:0] PSTA_BUS_RST   = 32'h0000_0000;
	localparam logic [15:0] PSTA_WORD_STEP = 16'h0002;
	localparam logic [15:0] PSTA_BYTE_STEP = 16'h0001;

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PSTA_OP_RD_LO = 2'h0,
		PSTA_OP_RD_HI = 2'h1,
		PSTA_OP_WR_LO = 2'h2,
		PSTA_OP_WR_HI = 2'h3
	} psta_op_t;

	typedef enum logic [1:0] {
		PSTA_ST_IDLE   = 2'h0,
		PSTA_ST_SETUP  = 2'h1,
		PSTA_ST_ACCESS = 2'h3
	} psta_state_t;

endpackage

/* File: verilog/psta_top.sv */
// Program-space table-access block: registers on AHB-Lite, sequencer to the program array.
// Assumes the array answers the mem_req held here with a one-cycle mem_ack.

// Operation
// - Low table operations reach the lower 16-bit word of any program address directly.
// - High table operations are the only data path to the upper 8 bits of a program word.
// - The program address steps by two for each successive program word.
// - Low operations select the low-word space and high operations the upper-byte space.
// - Every table read or write works in byte mode and in 16-bit word mode.
// - A word-mode low read returns program bits 15:0 unchanged.
// - A byte-mode low read returns the upper byte when byte select is one, else the lower.
// - A word-mode high read returns program bits 23:16 low with bits 15:8 forced to zero.
// - A byte-mode high read delivers the selected upper-word byte into data bits 7:0.
// - A byte-mode high read of the phantom byte returns zero.
// - Low and high table writes store single bytes or 16-bit words at a program address.
// - Each table operation takes its memory region from the table page register.
// - Page bit 7 clear selects user space and set selects configuration space.
// - The program space window is suspended while a table operation runs.
module psta_top
	import psta_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             mem_req,
	output logic             mem_we,
	output logic             mem_hi,
	output logic      [22:0] mem_addr,
	output logic      [15:0] mem_wdata,
	output logic      [1:0]  mem_wstrb,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             cfg_space,
	output logic             psv_suspend
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		psta_state_t st;
		logic [7:0]  page;
		logic [15:0] ea;
		logic [15:0] wdata;
		logic [15:0] rdata;
		psta_op_t    op;
		logic        byte_mode;
		logic        inc;
		logic [7:0]  op_page;
		logic [15:0] op_ea;
		logic [15:0] op_wdata;
		logic        ignored;
		logic        mem_req;
		logic        mem_we;
		logic        mem_hi;
		logic [22:0] mem_addr;
		logic [15:0] mem_wdata;
		logic [1:0]  mem_wstrb;
		logic        cfg;
		logic        suspend;
		logic [31:0] hrdata;
	} psta_core_t;

	psta_core_t  core_reg;
	psta_core_t  core_next;
	logic        done;
	logic [31:0] rd_mux;

	psta_bus_if  bus ();
	psta_lane_if lane ();

	// ------------------------------------------------------------
	// Helper modules
	// ------------------------------------------------------------
	psta_ahb_cap u_cap (
		.clk      (clk),
		.rst      (rst),
		.hsel     (hsel),
		.haddr_lo (haddr[7:0]),
		.htrans   (htrans),
		.hwrite   (hwrite),
		.hready   (hready),
		.bus      (bus.cap)
	);

	psta_lane u_lane (
		.clk  (clk),
		.rst  (rst),
		.lane (lane.lane)
	);

	// Formatter controls and write data come from the latched operation; read data comes straight from the array
	assign lane.op        = core_reg.op;
	assign lane.byte_mode = core_reg.byte_mode;
	assign lane.bsel      = core_reg.op_ea[0];
	assign lane.wdata     = core_reg.op_wdata;
	assign lane.rdata     = mem_rdata;

	// ------------------------------------------------------------
	// Register read multiplexer
	// ------------------------------------------------------------
	always_comb begin
		rd_mux = PSTA_BUS_RST;
		unique case (bus.addr)
			PSTA_OFF_PAGE:   rd_mux = {24'h00_0000, core_reg.page};
			PSTA_OFF_EA:     rd_mux = {16'h0000, core_reg.ea};
			PSTA_OFF_WDATA:  rd_mux = {16'h0000, core_reg.wdata};
			PSTA_OFF_CMD:    rd_mux = {28'h000_0000, core_reg.inc, core_reg.byte_mode,
				core_reg.op};
			PSTA_OFF_RDATA:  rd_mux = {16'h0000, core_reg.rdata};
			PSTA_OFF_STATUS: rd_mux = {29'h0000_0000, core_reg.ignored,
				core_reg.page[PSTA_PAGE_CFG_BIT], core_reg.suspend};
			default:         rd_mux = PSTA_BUS_RST; // Unmapped reads as zero
		endcase
	end

	// ------------------------------------------------------------
	// Register file and table operation sequencer
	// ------------------------------------------------------------
	always_comb begin
		core_next = core_reg;
		done = 1'b0;
		if (bus.rd_en) begin
			core_next.hrdata = rd_mux;
		end
		// Software writes
		if (bus.wr_en) begin
			unique case (bus.addr)
				PSTA_OFF_PAGE:  core_next.page = hwdata[7:0];
				PSTA_OFF_EA:    core_next.ea = hwdata[15:0];
				PSTA_OFF_WDATA: core_next.wdata = hwdata[15:0];
				PSTA_OFF_CMD: begin
					if (core_reg.st == PSTA_ST_IDLE) begin
						core_next.op        = psta_op_t'(hwdata[PSTA_CMD_OP_LSB +: 2]);
						core_next.byte_mode = hwdata[PSTA_CMD_BYTE_BIT];
						core_next.inc       = hwdata[PSTA_CMD_INC_BIT];
						core_next.op_page   = core_reg.page;
						core_next.op_ea     = core_reg.ea;
						core_next.op_wdata  = core_reg.wdata;
						core_next.suspend   = 1'b1;
						core_next.st        = PSTA_ST_SETUP;
					end else begin
						core_next.ignored = 1'b1; // Command while busy is dropped
					end
				end
				PSTA_OFF_STATUS: begin
					if (hwdata[PSTA_ST_IGN_BIT]) begin
						core_next.ignored = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		unique case (core_reg.st)
			PSTA_ST_IDLE: begin
			end
			PSTA_ST_SETUP: begin
				core_next.mem_addr  = {core_reg.op_page, core_reg.op_ea[15:1]};
				core_next.mem_hi    = core_reg.op[0];
				core_next.mem_we    = core_reg.op[1];
				core_next.mem_wdata = lane.wr_data;
				core_next.mem_wstrb = lane.wr_strb;
				core_next.cfg       = core_reg.op_page[PSTA_PAGE_CFG_BIT];
				if (core_reg.op[1] && lane.wr_strb == 2'h0) begin
					done = 1'b1; // Phantom byte write touches nothing
				end else begin
					core_next.mem_req = 1'b1;
					core_next.st      = PSTA_ST_ACCESS;
				end
			end
			PSTA_ST_ACCESS: begin
				if (mem_ack) begin
					core_next.mem_req = 1'b0;
					if (!core_reg.op[1]) begin
						core_next.rdata = lane.rd_fmt;
					end
					done = 1'b1;
				end
			end
			default: core_next.st = PSTA_ST_IDLE; // Illegal code recovers
		endcase
		// Completion and optional post-increment
		if (done) begin
			core_next.st        = PSTA_ST_IDLE;
			core_next.suspend   = 1'b0;
			core_next.mem_we    = 1'b0;
			core_next.mem_wstrb = 2'h0;
			if (core_reg.inc) begin
				core_next.ea = core_reg.op_ea + (core_reg.byte_mode ? PSTA_BYTE_STEP :
					PSTA_WORD_STEP);
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_reg       <= '0;
			core_reg.st    <= PSTA_ST_IDLE;
			core_reg.page  <= PSTA_PAGE_RST;
			core_reg.ea    <= PSTA_EA_RST;
			core_reg.wdata <= PSTA_DATA_RST;
			core_reg.rdata <= PSTA_DATA_RST;
		end else begin
			core_reg <= core_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign hrdata      = core_reg.hrdata;
	assign hreadyout   = ~bus.rd_wait;
	assign hresp       = 1'b0; // Always OKAY
	assign mem_req     = core_reg.mem_req;
	assign mem_we      = core_reg.mem_we;
	assign mem_hi      = core_reg.mem_hi;
	assign mem_addr    = core_reg.mem_addr;
	assign mem_wdata   = core_reg.mem_wdata;
	assign mem_wstrb   = core_reg.mem_wstrb;
	assign cfg_space   = core_reg.cfg;
	assign psv_suspend = core_reg.suspend;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_lo_space_sel: assert property (@(posedge clk) disable iff (rst)
		(mem_req && !core_reg.op[0]) |-> !mem_hi)
		else $error("low operation reached the upper byte space");
	a_hi_space_sel: assert property (@(posedge clk) disable iff (rst)
		(mem_req && core_reg.op[0]) |-> mem_hi)
		else $error("high operation missed the upper byte space");
	a_space_pair: assert property (@(posedge clk) disable iff (rst)
		$rose(mem_req) |-> (mem_hi == $past(core_reg.op[0])) && mem_addr[14:0] ==
		$past(core_reg.op_ea[15:1]))
		else $error("space or word index wrong at request");
	a_ea_word_step: assert property (@(posedge clk) disable iff (rst)
		(core_reg.st == PSTA_ST_ACCESS && mem_ack && core_reg.inc && !core_reg.byte_mode)
		|=> core_reg.ea == $past(core_reg.op_ea) + 16'h0002)
		else $error("address did not step by two");
	a_addr_concat: assert property (@(posedge clk) disable iff (rst)
		mem_req |-> mem_addr == {core_reg.op_page, core_reg.op_ea[15:1]})
		else $error("array address not page above effective address");
	a_page_source: assert property (@(posedge clk) disable iff (rst)
		(bus.wr_en && bus.addr == PSTA_OFF_CMD && core_reg.st == PSTA_ST_IDLE)
		|=> core_reg.op_page == $past(core_reg.page) ##2 mem_addr[22:15] == core_reg.op_page)
		else $error("operation did not take the table page");
	a_cfg_select: assert property (@(posedge clk) disable iff (rst)
		mem_req |-> cfg_space == core_reg.op_page[PSTA_PAGE_CFG_BIT])
		else $error("user or configuration space wrong");
	a_psv_hold: assert property (@(posedge clk) disable iff (rst)
		(core_reg.st != PSTA_ST_IDLE) |-> psv_suspend)
		else $error("window not suspended during table operation");
	a_write_store: assert property (@(posedge clk) disable iff (rst)
		(mem_req && core_reg.op[1]) |-> mem_we && mem_wstrb != 2'h0)
		else $error("table write without store strobes");
	a_byte_strobe: assert property (@(posedge clk) disable iff (rst)
		(mem_req && mem_we && core_reg.byte_mode) |-> $onehot(mem_wstrb))
		else $error("byte write touched more than one lane");
	a_req_held: assert property (@(posedge clk) disable iff (rst)
		(mem_req && !mem_ack) |=> mem_req && $stable(mem_addr))
		else $error("request dropped before acknowledge");

	// Array port lanes per operation
	a_word_lanes: assert property (@(posedge clk) disable iff (rst)
		(mem_req && mem_we && !mem_hi && !core_reg.byte_mode) |-> mem_wstrb == 2'h3)
		else $error("low word write did not store both lanes");
	a_hi_lane: assert property (@(posedge clk) disable iff (rst)
		(mem_req && mem_we && mem_hi) |-> mem_wstrb == 2'h1)
		else $error("high write touched more than the upper byte lane");

	// Completion, post-increment and refusal
	a_done_release: assert property (@(posedge clk) disable iff (rst)
		(core_reg.st == PSTA_ST_ACCESS && mem_ack) |=> !mem_req && !psv_suspend &&
		core_reg.st == PSTA_ST_IDLE)
		else $error("operation did not release the array and the window");
	a_ea_byte_step: assert property (@(posedge clk) disable iff (rst)
		(core_reg.st == PSTA_ST_ACCESS && mem_ack && core_reg.inc && core_reg.byte_mode)
		|=> core_reg.ea == $past(core_reg.op_ea) + 16'h0001)
		else $error("byte mode address did not step by one");
	a_phantom_write: assert property (@(posedge clk) disable iff (rst)
		(core_reg.st == PSTA_ST_SETUP && core_reg.op == PSTA_OP_WR_HI &&
		core_reg.byte_mode && core_reg.op_ea[0]) |=> !mem_req && core_reg.st == PSTA_ST_IDLE)
		else $error("phantom byte write reached the array");
	a_busy_refuse: assert property (@(posedge clk) disable iff (rst)
		(bus.wr_en && bus.addr == PSTA_OFF_CMD && core_reg.st != PSTA_ST_IDLE)
		|=> core_reg.ignored && $stable(core_reg.op))
		else $error("command while busy was not refused");

	// Bus answer timing
	a_read_wait: assert property (@(posedge clk) disable iff (rst)
		bus.rd_wait |-> !hreadyout ##1 hreadyout)
		else $error("read wait state not exactly one cycle");

endmodule
